// ### core/npsp_pkg.sv
// Constants and carrier types for the nibble port and serial pin selection.
// Assumes an 8-bit internal register bus with 12-bit byte addresses.
package npsp_pkg;

   localparam int         ADDR_W           = 12;
   localparam logic [11:0] ADDR_LATCH      = 12'h00B;
   localparam logic [11:0] ADDR_PIN_STATE  = 12'h018;
   localparam logic [11:0] ADDR_DIRECTION  = 12'hF25;
   localparam logic [11:0] ADDR_FUNC_EN    = 12'hF3F;
   localparam logic [11:0] ADDR_DRIVE_TYPE = 12'hF4C;
   localparam logic [11:0] ADDR_SERIAL_SEL = 12'hFCB;

   localparam logic [7:0] RST_LATCH        = 8'h00;
   localparam logic [7:0] RST_DIRECTION    = 8'h00;
   localparam logic [7:0] RST_FUNC_EN      = 8'h00;
   localparam logic [7:0] RST_DRIVE_TYPE   = 8'h00;
   localparam logic [7:0] RST_SERIAL_SEL   = 8'h00;

   // Writable bits of each register; all others read as zero
   localparam logic [7:0] MASK_NIBBLE      = 8'hF0;
   localparam logic [7:0] MASK_FUNC_EN     = 8'h70;
   localparam logic [7:0] MASK_SERIAL_SEL  = 8'hD3;

   // Field positions in the serial pin selection register
   localparam int SEL_COMBO_LSB            = 0;
   localparam int SEL_GROUP_BIT            = 4;
   localparam int SEL_TIMER_LSB            = 6;

   localparam int SYNC_STAGES_W            = 9;

   typedef enum logic [1:0]
   {
      NPSP_ASYNC_TWO_WIRE,
      NPSP_ASYNC_SYNC,
      NPSP_SYNC_TWO_WIRE,
      NPSP_COMBO_RSVD
   } npsp_combo_e;

   typedef enum logic [1:0]
   {
      NPSP_TMR_DEDICATED,
      NPSP_TMR_ASYNC_FIRST,
      NPSP_TMR_ASYNC_SECOND,
      NPSP_TMR_RSVD
   } npsp_timer_sel_e;

   typedef struct packed
   {
      logic [3:0] lvl;
      logic [3:0] oe;
   } npsp_pin_drv_s;

   typedef struct packed
   {
      logic async_first;
      logic sync_serial;
      logic two_wire;
   } npsp_unit_en_s;

endpackage

// ### core/npsp_sync.sv
// Two-stage synchroniser array for pin levels entering the core clock.
// Assumes inputs are asynchronous; clock enable freezes both stages.
`timescale 1ns/1ps
module npsp_sync #(
   parameter int W = 1
) (
   input  wire logic         CORE_CLK,
   input  wire logic         RST_N,
   input  wire logic         CLK_EN,
   input  wire logic [W-1:0] ASYNC_IN,
   output logic      [W-1:0] SYNC_OUT
);
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         logic meta_ff;
         logic stable_ff;
         // First stage feeds only the second stage
         always_ff @(posedge CORE_CLK)
         begin
            if (!RST_N)
            begin
               meta_ff   <= 1'b0;
               stable_ff <= 1'b0;
            end
            else if (CLK_EN)
            begin
               meta_ff   <= ASYNC_IN[g];
               stable_ff <= meta_ff;
            end
         end
         assign SYNC_OUT[g] = stable_ff;
      end
   endgenerate
endmodule // npsp_sync

// ### core/npsp_nibble_port.sv
// Four-pin bidirectional port (bits 7..4) with serial pin selection.
// Assumes a same-clock internal bus and same-clock serial/timer units.
// Functional notes
// - Four pins 7..4, each input or output
// - Drive bit: 0 push-pull, 1 open-drain
// - Latch 7..4 drives level; 3..0 read 0
// - Direction bit: 0 input, 1 output
// - Function enables 6..4 pick serial outputs
// - Bits 6..4 carry serial clock, data lines
// - Combination field enables two of three units; reserved code enables none
// - Selection reassigns pins and event latches
// - Group bit: alternate pins or this port
// - Timer field picks capture input source
// - Swap bit exchanges alternate receive and transmit pins; on this port it moves receive only
`timescale 1ns/1ps
module npsp_nibble_port (
   input  wire logic                   CORE_CLK,
   input  wire logic                   RST_N,
   input  wire logic                   CLK_EN,
   input  wire logic [11:0]            BUS_ADDR,
   input  wire logic                   BUS_WR,
   input  wire logic                   BUS_RD,
   input  wire logic [7:0]             BUS_WDATA,
   output logic      [7:0]             BUS_RDATA,
   input  wire logic [3:0]             PIN_IN,
   output npsp_pkg::npsp_pin_drv_s     PIN_DRV,
   input  wire logic [2:0]             ALT_PIN_IN,
   input  wire logic                   DEDICATED_TIMER_PIN,
   input  wire logic                   SECOND_ASYNC_RX_PIN,
   input  wire logic                   ASYNC_PIN_SWAP,
   input  wire logic                   SYNC_SERIAL_CLOCK,
   input  wire logic                   SYNC_SERIAL_OUTPUT,
   input  wire logic                   ASYNC_TRANSMIT_FIRST,
   input  wire logic                   ASYNC_RECEIVE_EVENT,
   input  wire logic                   SYNC_SERIAL_EVENT,
   input  wire logic                   TWO_WIRE_EVENT,
   output logic                        ASYNC_RECEIVE_FIRST,
   output logic                        SYNC_SERIAL_INPUT,
   output logic                        CAPTURE_TIMER_INPUT,
   output npsp_pkg::npsp_unit_en_s     UNIT_EN,
   output logic      [2:0]             ALT_FN_OUT,
   output logic      [2:0]             ALT_FN_SEL,
   output logic                        LATCH_SRC_RX,
   output logic                        LATCH_SRC_SBI
);
   import npsp_pkg::*;

   logic [7:0]      latch_ff;
   logic [7:0]      dir_ff;
   logic [7:0]      fe_ff;
   logic [7:0]      drv_ff;
   logic [7:0]      sel_ff;
   logic [8:0]      sync_lvl;
   logic [3:0]      pin_lvl;
   logic [2:0]      alt_lvl;
   logic            ded_lvl;
   logic            rx2_lvl;
   npsp_combo_e     combo;
   npsp_timer_sel_e tsel;
   logic            grp_port;
   logic            grp_sync;
   logic [3:0]      fn_val;
   logic [3:0]      nxt_lvl;
   logic [3:0]      nxt_oe;
   logic [7:0]      pin_state;
   logic [7:0]      nxt_rdata;

   npsp_sync #(.W(SYNC_STAGES_W)) u_sync (
      .CORE_CLK (CORE_CLK),
      .RST_N    (RST_N),
      .CLK_EN   (CLK_EN),
      .ASYNC_IN ({SECOND_ASYNC_RX_PIN, DEDICATED_TIMER_PIN, ALT_PIN_IN,
                  PIN_IN}),
      .SYNC_OUT (sync_lvl)
   );
   assign pin_lvl = sync_lvl[3:0];
   assign alt_lvl = sync_lvl[6:4];
   assign ded_lvl = sync_lvl[7];
   assign rx2_lvl = sync_lvl[8];

   assign combo    = npsp_combo_e'(sel_ff[SEL_COMBO_LSB +: 2]);
   assign tsel     = npsp_timer_sel_e'(sel_ff[SEL_TIMER_LSB +: 2]);
   assign grp_port = sel_ff[SEL_GROUP_BIT];
   // The shared group carries the sync unit only when async is off
   assign grp_sync = (combo == NPSP_SYNC_TWO_WIRE);

   // Register writes; masks keep unused bits at zero
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         latch_ff <= RST_LATCH;
         dir_ff   <= RST_DIRECTION;
         fe_ff    <= RST_FUNC_EN;
         drv_ff   <= RST_DRIVE_TYPE;
         sel_ff   <= RST_SERIAL_SEL;
      end
      else if (CLK_EN && BUS_WR)
      begin
         case (BUS_ADDR)
            ADDR_LATCH:      latch_ff <= BUS_WDATA & MASK_NIBBLE;
            ADDR_DIRECTION:  dir_ff   <= BUS_WDATA & MASK_NIBBLE;
            ADDR_FUNC_EN:    fe_ff    <= BUS_WDATA & MASK_FUNC_EN;
            ADDR_DRIVE_TYPE: drv_ff   <= BUS_WDATA & MASK_NIBBLE;
            ADDR_SERIAL_SEL: sel_ff   <= BUS_WDATA & MASK_SERIAL_SEL;
            default:         ;
         endcase
      end
   end

   // Peripheral output per pin; bit 7 has none
   always_comb
   begin
      fn_val    = 4'h0;
      fn_val[0] = grp_sync ? SYNC_SERIAL_OUTPUT : ASYNC_TRANSMIT_FIRST;
      fn_val[1] = ASYNC_TRANSMIT_FIRST;
      fn_val[2] = SYNC_SERIAL_CLOCK;
   end

   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_pin
         logic val;
         assign val = (fe_ff[i+4] & dir_ff[i+4]) ? fn_val[i]
                                                 : latch_ff[i+4];
         // Open drain only ever sinks; release means high
         assign nxt_lvl[i] = drv_ff[i+4] ? 1'b0 : val;
         assign nxt_oe[i]  = dir_ff[i+4] & (~drv_ff[i+4] | ~val);
         assign pin_state[i+4] = (~dir_ff[i+4] | drv_ff[i+4])
                                 & pin_lvl[i];
      end
   endgenerate
   assign pin_state[3:0] = 4'h0;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         PIN_DRV <= '0;
      end
      else if (CLK_EN)
      begin
         PIN_DRV.lvl <= nxt_lvl;
         PIN_DRV.oe  <= nxt_oe;
      end
   end

   always_comb
   begin
      case (BUS_ADDR)
         ADDR_LATCH:      nxt_rdata = latch_ff;
         ADDR_PIN_STATE:  nxt_rdata = pin_state;
         ADDR_DIRECTION:  nxt_rdata = dir_ff;
         ADDR_FUNC_EN:    nxt_rdata = fe_ff;
         ADDR_DRIVE_TYPE: nxt_rdata = drv_ff;
         ADDR_SERIAL_SEL: nxt_rdata = sel_ff;
         default:         nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         BUS_RDATA <= 8'h00;
      end
      else if (CLK_EN && BUS_RD)
      begin
         BUS_RDATA <= nxt_rdata;
      end
   end

   // Routing of serial, timer and event signals
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         ASYNC_RECEIVE_FIRST <= 1'b0;
         SYNC_SERIAL_INPUT   <= 1'b0;
         CAPTURE_TIMER_INPUT <= 1'b0;
         UNIT_EN             <= '0;
         ALT_FN_OUT          <= 3'h0;
         ALT_FN_SEL          <= 3'h0;
         LATCH_SRC_RX        <= 1'b0;
         LATCH_SRC_SBI       <= 1'b0;
      end
      else if (CLK_EN)
      begin
         if (grp_port)
         begin
            ASYNC_RECEIVE_FIRST <= ASYNC_PIN_SWAP ? pin_lvl[0]
                                                  : pin_lvl[1];
            SYNC_SERIAL_INPUT   <= pin_lvl[1];
            ALT_FN_SEL          <= 3'h0;
         end
         else
         begin
            ASYNC_RECEIVE_FIRST <= ASYNC_PIN_SWAP ? alt_lvl[0]
                                                  : alt_lvl[1];
            SYNC_SERIAL_INPUT   <= alt_lvl[1];
            ALT_FN_SEL <= grp_sync ? 3'b101
                                   : {1'b0, ASYNC_PIN_SWAP,
                                      ~ASYNC_PIN_SWAP};
         end
         ALT_FN_OUT <= grp_sync ? {SYNC_SERIAL_CLOCK, 1'b0,
                                   SYNC_SERIAL_OUTPUT}
                                : {1'b0, ASYNC_TRANSMIT_FIRST,
                                   ASYNC_TRANSMIT_FIRST};
         case (tsel)
            NPSP_TMR_DEDICATED:    CAPTURE_TIMER_INPUT <= ded_lvl;
            NPSP_TMR_ASYNC_FIRST:  CAPTURE_TIMER_INPUT <= alt_lvl[1];
            NPSP_TMR_ASYNC_SECOND: CAPTURE_TIMER_INPUT <= rx2_lvl;
            default:               CAPTURE_TIMER_INPUT <= 1'b0;
         endcase
         // Reserved combination enables nothing so no unit misroutes
         case (combo)
            NPSP_ASYNC_TWO_WIRE:
            begin
               UNIT_EN       <= 3'b101;
               LATCH_SRC_RX  <= ASYNC_RECEIVE_EVENT;
               LATCH_SRC_SBI <= TWO_WIRE_EVENT;
            end
            NPSP_ASYNC_SYNC:
            begin
               UNIT_EN       <= 3'b110;
               LATCH_SRC_RX  <= ASYNC_RECEIVE_EVENT;
               LATCH_SRC_SBI <= SYNC_SERIAL_EVENT;
            end
            NPSP_SYNC_TWO_WIRE:
            begin
               UNIT_EN       <= 3'b011;
               LATCH_SRC_RX  <= SYNC_SERIAL_EVENT;
               LATCH_SRC_SBI <= TWO_WIRE_EVENT;
            end
            default:
            begin
               UNIT_EN       <= 3'b000;
               LATCH_SRC_RX  <= 1'b0;
               LATCH_SRC_SBI <= 1'b0;
            end
         endcase
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   latch_write_a: assert property (CLK_EN && BUS_WR && BUS_ADDR == ADDR_LATCH
      |=> latch_ff == ($past(BUS_WDATA) & 8'hF0))
      else $error("latch write not masked to upper nibble");
   dir_read_a: assert property (CLK_EN && BUS_RD && BUS_ADDR == ADDR_DIRECTION
      |=> BUS_RDATA[3:0] == 4'h0)
      else $error("direction low bits not zero");
   fe_bit7_a: assert property (CLK_EN && BUS_RD && BUS_ADDR == ADDR_FUNC_EN
      |=> !BUS_RDATA[7])
      else $error("function enable bit 7 not zero");
   pin_state_a: assert property (CLK_EN && BUS_RD
      && BUS_ADDR == ADDR_PIN_STATE
      |=> (BUS_RDATA & $past(dir_ff & ~drv_ff)) == 8'h00)
      else $error("push-pull output pin state not zero");
   push_pull_a: assert property (CLK_EN && dir_ff == 8'hF0 && drv_ff == 8'h00
      && fe_ff == 8'h00
      |=> PIN_DRV.oe == 4'hF && PIN_DRV.lvl == $past(latch_ff[7:4]))
      else $error("push-pull pin does not follow latch");
   open_drain_a: assert property (CLK_EN && drv_ff[7:4] != 4'h0
      |=> (PIN_DRV.lvl & $past(drv_ff[7:4])) == 4'h0)
      else $error("open-drain pin driven high");
   input_mode_a: assert property (CLK_EN && dir_ff[7:4] == 4'h0
      |=> PIN_DRV.oe == 4'h0)
      else $error("input pin driven");
   unit_combo_a: assert property (CLK_EN && combo == NPSP_ASYNC_SYNC
      |=> UNIT_EN == 3'b110)
      else $error("wrong unit enables");
   event_route_a: assert property (CLK_EN && combo == NPSP_SYNC_TWO_WIRE
      |=> LATCH_SRC_RX == $past(SYNC_SERIAL_EVENT))
      else $error("sync event not routed to shared latch");
   timer_sel_a: assert property (CLK_EN && tsel == NPSP_TMR_DEDICATED
      |=> CAPTURE_TIMER_INPUT == $past(ded_lvl))
      else $error("timer input not from dedicated pin");
   swap_rx_a: assert property (CLK_EN && grp_port && ASYNC_PIN_SWAP
      |=> ASYNC_RECEIVE_FIRST == $past(pin_lvl[0]))
      else $error("swapped receive not on bit 4");

   cov_fn_drive: cover property (fe_ff[6] && dir_ff[6] && PIN_DRV.oe[2]);
   cov_od_read: cover property (BUS_RD && BUS_ADDR == ADDR_PIN_STATE
      && dir_ff[4] && drv_ff[4]);
   cov_sync_grp: cover property (grp_port && combo == NPSP_SYNC_TWO_WIRE);
endmodule // npsp_nibble_port

// ### verification/npsp_pin_model.sv
// External circuitry on the four port pins.
// Assumes PIN_DRV from the port; released pins show the level set by the
// bench, so a stale driven value never lingers on the wire.
`timescale 1ns/1ps
module npsp_pin_model (
   input  wire logic [3:0]              ext_lvl,
   input  wire npsp_pkg::npsp_pin_drv_s drv,
   output logic      [3:0]              pin
);
   import npsp_pkg::*;

   // Driven pins win; open-drain high is a release
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         pin[i] = drv.oe[i] ? drv.lvl[i] : ext_lvl[i];
      end
   end
endmodule // npsp_pin_model

// ### verification/nibble_port_serial_pin_select_bench.sv
// Self-checking bench for the nibble port and serial pin selection.
// Assumes the pin model on the port pins and a one-clock register bus.
`timescale 1ns/1ps
module nibble_port_serial_pin_select_bench;
   import npsp_pkg::*;

   logic           clk = 1'b0;
   logic           rst_n = 1'b0;
   logic           bus_wr = 1'b0;
   logic           bus_rd = 1'b0;
   logic [11:0]    bus_addr = 12'h000;
   logic [7:0]     bus_wdata = 8'h00;
   logic [7:0]     bus_rdata;
   logic [3:0]     ext_lvl = 4'h0;
   logic [3:0]     pin;
   npsp_pin_drv_s  drv;
   logic [2:0]     alt_in = 3'h0;
   logic           ded = 1'b0;
   logic           rx2 = 1'b0;
   logic           swap = 1'b0;
   logic           sclk = 1'b0;
   logic           tx = 1'b0;
   logic           ev_rx = 1'b0;
   logic           ev_sio = 1'b0;
   logic           ev_sbi = 1'b0;
   logic           clk_en = 1'b1;
   logic           sout = 1'b0;
   logic           rxf, sin, cap, lrx, lsbi;
   npsp_unit_en_s  uen;
   logic [2:0]     afo, afs;
   int             n_errors = 0;
   int             n_tests = 0;
   int             cyc = 0;

   always #5 clk = ~clk;

   npsp_pin_model pm_u (.ext_lvl(ext_lvl), .drv(drv), .pin(pin));

   npsp_nibble_port dut_u (
      .CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en),
      .BUS_ADDR(bus_addr), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
      .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata),
      .PIN_IN(pin), .PIN_DRV(drv), .ALT_PIN_IN(alt_in),
      .DEDICATED_TIMER_PIN(ded), .SECOND_ASYNC_RX_PIN(rx2),
      .ASYNC_PIN_SWAP(swap), .SYNC_SERIAL_CLOCK(sclk),
      .SYNC_SERIAL_OUTPUT(sout), .ASYNC_TRANSMIT_FIRST(tx),
      .ASYNC_RECEIVE_EVENT(ev_rx), .SYNC_SERIAL_EVENT(ev_sio),
      .TWO_WIRE_EVENT(ev_sbi), .ASYNC_RECEIVE_FIRST(rxf),
      .SYNC_SERIAL_INPUT(sin), .CAPTURE_TIMER_INPUT(cap), .UNIT_EN(uen),
      .ALT_FN_OUT(afo), .ALT_FN_SEL(afs),
      .LATCH_SRC_RX(lrx), .LATCH_SRC_SBI(lsbi));

   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(logic [11:0] a, logic [7:0] d);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr    <= 1'b0;
      @(posedge clk);
   endtask

   // Strobe held until the taking edge; data read once it has landed
   task automatic rdchk(logic [11:0] a, logic [7:0] exp);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd   <= 1'b0;
      #1;
      chk("read data", bus_rdata, exp);
      @(posedge clk);
   endtask

   // Routing and pin paths settle within three edges
   task automatic settle;
      repeat (5) @(posedge clk);
   endtask

   task automatic t_reset_and_masks;
      logic [11:0] adr[5] = '{ADDR_LATCH, ADDR_DIRECTION, ADDR_DRIVE_TYPE,
                              ADDR_FUNC_EN, ADDR_SERIAL_SEL};
      logic [7:0]  msk[5] = '{8'hF0, 8'hF0, 8'hF0, 8'h70, 8'hD3};
      for (int i = 0; i < 5; i++)
      begin
         rdchk(adr[i], 8'h00);
         wr(adr[i], 8'hFF);
         rdchk(adr[i], msk[i]);
         wr(adr[i], 8'h00);
      end
      wr(12'h001, 8'hFF);
      rdchk(12'h001, 8'h00);
   endtask

   task automatic t_pins;
      ext_lvl <= 4'hF;
      wr(ADDR_DIRECTION, 8'hF0);
      wr(ADDR_LATCH, 8'hA0);
      settle();
      chk("pin level", {4'h0, drv.lvl}, 8'h0A);
      chk("pin enable", {4'h0, drv.oe}, 8'h0F);
      rdchk(ADDR_PIN_STATE, 8'h00);
      wr(ADDR_DRIVE_TYPE, 8'hF0);
      settle();
      chk("od enable", {4'h0, drv.oe}, 8'h05);
      chk("od level", {4'h0, drv.lvl}, 8'h00);
      rdchk(ADDR_PIN_STATE, 8'hA0);
      wr(ADDR_DRIVE_TYPE, 8'h00);
      wr(ADDR_DIRECTION, 8'h00);
      ext_lvl <= 4'h6;
      settle();
      chk("input enable", {4'h0, drv.oe}, 8'h00);
      rdchk(ADDR_PIN_STATE, 8'h60);
   endtask

   task automatic t_select;
      logic [2:0] en[4] = '{3'b101, 3'b110, 3'b011, 3'b000};
      logic       cp[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
      logic       rl[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      logic       sl[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      ded    <= 1'b1;
      rx2    <= 1'b1;
      alt_in <= 3'b010;
      ev_rx  <= 1'b1;
      ev_sbi <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_SERIAL_SEL, {i[1:0], 4'h0, i[1:0]});
         settle();
         chk("unit enables", {5'h00, uen}, {5'h00, en[i]});
         chk("capture input", {7'h00, cap}, {7'h00, cp[i]});
         chk("rx latch source", {7'h00, lrx}, {7'h00, rl[i]});
         chk("sbi latch source", {7'h00, lsbi}, {7'h00, sl[i]});
      end
      // Events dropped once the new selection is in place
      alt_in <= 3'b000;
      ev_rx  <= 1'b0;
      ev_sbi <= 1'b0;
   endtask

   task automatic t_func_and_route;
      sclk <= 1'b1;
      tx   <= 1'b1;
      wr(ADDR_SERIAL_SEL, 8'h11);
      wr(ADDR_DIRECTION, 8'hF0);
      wr(ADDR_LATCH, 8'h00);
      wr(ADDR_FUNC_EN, 8'h50);
      settle();
      chk("function level", {4'h0, drv.lvl}, 8'h05);
      wr(ADDR_FUNC_EN, 8'h00);
      settle();
      chk("latch level", {4'h0, drv.lvl}, 8'h00);
      wr(ADDR_DIRECTION, 8'h00);
      ext_lvl <= 4'h2;
      settle();
      chk("sync input", {7'h00, sin}, 8'h01);
      wr(ADDR_SERIAL_SEL, 8'h10);
      settle();
      chk("receive pin5", {7'h00, rxf}, 8'h01);
      swap    <= 1'b1;
      ext_lvl <= 4'h1;
      settle();
      chk("swapped receive", {7'h00, rxf}, 8'h01);
   endtask

   // Alternate group outputs, sync output on bit 4, clock-enable freeze
   task automatic t_alt_and_freeze;
      swap   <= 1'b0;
      sout   <= 1'b1;
      alt_in <= 3'b010;
      wr(ADDR_SERIAL_SEL, 8'h02);
      settle();
      chk("alt select", {5'h00, afs}, 8'h05);
      chk("alt output", {5'h00, afo}, 8'h05);
      wr(ADDR_SERIAL_SEL, 8'h00);
      settle();
      chk("alt select", {5'h00, afs}, 8'h01);
      chk("alt output", {5'h00, afo}, 8'h03);
      chk("alt receive", {7'h00, rxf}, 8'h01);
      alt_in <= 3'b000;
      sout   <= 1'b0;
      wr(ADDR_SERIAL_SEL, 8'h12);
      wr(ADDR_DIRECTION, 8'hF0);
      wr(ADDR_LATCH, 8'hF0);
      wr(ADDR_FUNC_EN, 8'h10);
      settle();
      chk("sync output pin", {4'h0, drv.lvl}, 8'h0E);
      // Frozen core must ignore the write and the new unit output
      clk_en <= 1'b0;
      sout   <= 1'b1;
      wr(ADDR_LATCH, 8'h00);
      settle();
      chk("frozen level", {4'h0, drv.lvl}, 8'h0E);
      clk_en <= 1'b1;
      rdchk(ADDR_LATCH, 8'hF0);
      settle();
      chk("sync output pin", {4'h0, drv.lvl}, 8'h0F);
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset_and_masks();
      t_pins();
      t_select();
      t_func_and_route();
      t_alt_and_freeze();
      report_and_stop();
   end
endmodule // nibble_port_serial_pin_select_bench
